// file: diag_bits_defs.vh
// Constants for the diagnostic control byte of the vector offset register
`ifndef DIAG_BITS_DEFS_VH
`define DIAG_BITS_DEFS_VH

// Register offset of the diagnostic low byte
`define VOR_DIAG_LOW_ADDR    4'h0
// Offset of the suite status register
`define SUITE_STATUS_ADDR    4'h1
// Address bus width
`define REG_ADDR_W           4

// Field positions
`define RSVD_BIT             7
`define TEST_FAIL_BIT        6
`define LOOPBACK_BIT         5
`define DRV_DISABLE_BIT      4
`define MASK_MSB             3
`define MASK_LSB             0

// Reset values
`define TEST_FAIL_RST        1'h0
`define LOOPBACK_RST         1'h0
`define DRV_DISABLE_RST      1'h0
`define MASK_RST             4'h0
`define RDATA_RST            8'h00

`endif

// file: diag_mask_hold.v
// Holder for the internal bus mask field, written only through its own path
`timescale 1ns/10ps

module diag_mask_hold (
    // Clock and reset
    input  wire       clk_i,
    input  wire       srst_i,
    // Internal bus field path
    input  wire       mask_we_i,
    input  wire [3:0] mask_wdata_i,
    // Held value
    output reg  [3:0] mask_o
);

`include "diag_bits_defs.vh"

    // **************************************
    // Mask storage
    // **************************************
    // Only the internal bus path loads the field; register writes never reach here
    always @(posedge clk_i) begin
        if (srst_i) begin
            mask_o <= `MASK_RST;            // RULE6
        end else if (mask_we_i) begin
            mask_o <= mask_wdata_i;         // RULE6
        end
    end

endmodule

// file: adapter_diag_control_bits.v
// Diagnostic control and status bits of the adapter vector offset register
`timescale 1ns/10ps

// Overview of operation
// RULE1: bit 7 is read-only, reads zero
// RULE2: software sets test-fail flag at suite start
// RULE3: hardware clears test-fail when all tests pass
// RULE4: bit 5 one selects loopback mode
// RULE5: bit 4 one turns off backplane drivers
// RULE6: mask field read-only, loaded via internal bus
// RULE7: ordinary software leaves the mask field alone
// RULE8: writes to bit 7 and mask ignored
module adapter_diag_control_bits (
    // Clock and reset
    input  wire       CLK_I,
    input  wire       SRST_I,
    // Register port
    input  wire [3:0] ADDR_I,
    input  wire [7:0] WDATA_I,
    input  wire       WR_I,
    input  wire       RD_I,
    output reg  [7:0] RDATA_O,
    // Diagnostic suite outcome
    input  wire       ALL_TESTS_PASS_I,
    // Internal bus interrupt field path to the mask
    input  wire       INTERNAL_BUS_MASK_WE_I,
    input  wire [3:0] INTERNAL_BUS_MASK_WDATA_I,
    // Controls to the adapter
    output reg        LOOPBACK_EN_O,
    output reg        BACKPLANE_DRV_DISABLE_O,
    output reg  [3:0] CPU_INTERNAL_BUS_MASK_O,
    output reg        TEST_FAIL_O
);

`include "diag_bits_defs.vh"

    // **************************************
    // State
    // **************************************
    reg        test_fail_r;        // Test-failure flag
    reg        loopback_r;         // Loopback mode select
    reg        drv_disable_r;      // Backplane driver disable
    reg        pass_seen_r;        // Last suite ended with all passing
    wire [3:0] mask_w;             // Held mask field
    wire       wr_diag;            // Write hits the diagnostic byte

    // Decode a register address match
    function hit;
        input [3:0] a;
        input [3:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    assign wr_diag = WR_I & hit(ADDR_I, `VOR_DIAG_LOW_ADDR);

    // **************************************
    // Mask field holder
    // **************************************
    diag_mask_hold u_mask (
        .clk_i        (CLK_I),
        .srst_i       (SRST_I),
        .mask_we_i    (INTERNAL_BUS_MASK_WE_I),
        .mask_wdata_i (INTERNAL_BUS_MASK_WDATA_I),
        .mask_o       (mask_w)
    );

    // **************************************
    // Writable control bits
    // **************************************
    // Bits 7 and 3:0 of write data are dropped here
    always @(posedge CLK_I) begin
        if (SRST_I) begin
            test_fail_r   <= `TEST_FAIL_RST;
            loopback_r    <= `LOOPBACK_RST;
            drv_disable_r <= `DRV_DISABLE_RST;
            pass_seen_r   <= 1'h0;
        end else begin
            // Software write of the flag wins over a pass in the same cycle
            if (wr_diag) begin
                test_fail_r <= WDATA_I[`TEST_FAIL_BIT];       // RULE2
            end else if (ALL_TESTS_PASS_I) begin
                test_fail_r <= 1'h0;                          // RULE3
            end
            if (wr_diag) begin
                loopback_r    <= WDATA_I[`LOOPBACK_BIT];      // RULE4
                drv_disable_r <= WDATA_I[`DRV_DISABLE_BIT];   // RULE5
            end
            // Pass history for the status register
            if (wr_diag && WDATA_I[`TEST_FAIL_BIT]) begin
                pass_seen_r <= 1'h0;
            end else if (ALL_TESTS_PASS_I) begin
                pass_seen_r <= 1'h1;
            end
        end
    end

    // **************************************
    // Outputs and read data
    // **************************************
    always @(posedge CLK_I) begin
        if (SRST_I) begin
            RDATA_O                 <= `RDATA_RST;
            LOOPBACK_EN_O           <= 1'h0;
            BACKPLANE_DRV_DISABLE_O <= 1'h0;
            CPU_INTERNAL_BUS_MASK_O <= `MASK_RST;
            TEST_FAIL_O             <= 1'h0;
        end else begin
            LOOPBACK_EN_O           <= loopback_r;            // RULE4
            BACKPLANE_DRV_DISABLE_O <= drv_disable_r;         // RULE5
            CPU_INTERNAL_BUS_MASK_O <= mask_w;                // RULE6
            TEST_FAIL_O             <= test_fail_r;
            // Read data valid only in the cycle after the strobe
            if (RD_I && hit(ADDR_I, `VOR_DIAG_LOW_ADDR)) begin
                RDATA_O <= {1'h0, test_fail_r, loopback_r,    // RULE1 RULE8
                            drv_disable_r, mask_w};
            end else if (RD_I && hit(ADDR_I, `SUITE_STATUS_ADDR)) begin
                RDATA_O <= {7'h00, pass_seen_r};
            end else begin
                RDATA_O <= `RDATA_RST;
            end
        end
    end

endmodule

// file: adapter_diag_control_bits_monitor.sv
// Checker for the diagnostic control byte ports
`timescale 1ns/10ps
module diag_ports_monitor (
    input logic       CLK_I,
    input logic       SRST_I,
    input logic [3:0] ADDR_I,
    input logic [7:0] WDATA_I,
    input logic       WR_I,
    input logic       RD_I,
    input logic [7:0] RDATA_O,
    input logic       ALL_TESTS_PASS_I,
    input logic       INTERNAL_BUS_MASK_WE_I,
    input logic [3:0] INTERNAL_BUS_MASK_WDATA_I,
    input logic       LOOPBACK_EN_O,
    input logic       BACKPLANE_DRV_DISABLE_O,
    input logic [3:0] CPU_INTERNAL_BUS_MASK_O,
    input logic       TEST_FAIL_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    wire dw = WR_I && ADDR_I == 4'h0;
    rsvd_zero_a: assert property (RD_I |=> !RDATA_O[7]) else $error("bit7 set");
    loop_follow_a: assert property (dw |-> ##2 LOOPBACK_EN_O == $past(WDATA_I[5], 2))
        else $error("loopback");
    drv_follow_a: assert property (dw |-> ##2 BACKPLANE_DRV_DISABLE_O == $past(WDATA_I[4], 2))
        else $error("driver off");
    fail_clear_a: assert property (ALL_TESTS_PASS_I && !(dw && WDATA_I[6]) |-> ##2 !TEST_FAIL_O)
        else $error("fail kept");
    mask_ro_a: assert property (!$past(INTERNAL_BUS_MASK_WE_I, 2) |-> $stable(CPU_INTERNAL_BUS_MASK_O))
        else $error("mask moved");
    mask_load_a: assert property (INTERNAL_BUS_MASK_WE_I |-> ##2 CPU_INTERNAL_BUS_MASK_O == $past(INTERNAL_BUS_MASK_WDATA_I, 2))
        else $error("mask load");
    cover property (dw ##2 LOOPBACK_EN_O);
    cover property (INTERNAL_BUS_MASK_WE_I);
    cover property (ALL_TESTS_PASS_I ##2 !TEST_FAIL_O);
endmodule
bind adapter_diag_control_bits diag_ports_monitor mon (.*);

// file: testbench.sv
// Self-checking bench for the diagnostic control byte
`timescale 1ns/10ps
module testbench;
    logic       CLK_I = 0, SRST_I = 1, WR_I = 0, RD_I = 0, ALL_TESTS_PASS_I = 0, INTERNAL_BUS_MASK_WE_I = 0;
    logic [3:0] ADDR_I = 4'h0, INTERNAL_BUS_MASK_WDATA_I = 4'h0, CPU_INTERNAL_BUS_MASK_O;
    logic [7:0] WDATA_I = 8'h00, RDATA_O;
    logic       LOOPBACK_EN_O, BACKPLANE_DRV_DISABLE_O, TEST_FAIL_O;
    int         num_errors = 0, checks = 0;
    wire  [7:0] ctl = {1'b0, TEST_FAIL_O, LOOPBACK_EN_O, BACKPLANE_DRV_DISABLE_O, CPU_INTERNAL_BUS_MASK_O};
    adapter_diag_control_bits dut (.*);
    initial forever #10 CLK_I = ~CLK_I;
    task chk(input string n, input logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task conclude;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK_I) {WR_I, ADDR_I, WDATA_I} <= {1'b1, a, d};
        @(posedge CLK_I) WR_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge CLK_I) {RD_I, ADDR_I} <= {1'b1, a};
        @(posedge CLK_I) RD_I <= 1'b0;
        #1 chk("read", RDATA_O, e);
    endtask
    initial begin
        repeat (6) @(posedge CLK_I);
        SRST_I <= 1'b0;
        #1 chk("reset", ctl, 8'h00);
        rd(4'h0, 8'h00);
        wr(4'h0, 8'hFF);
        #1 chk("controls", ctl, 8'h70);
        rd(4'h0, 8'h70);
        @(posedge CLK_I) {INTERNAL_BUS_MASK_WE_I, INTERNAL_BUS_MASK_WDATA_I} <= 5'h1A;
        @(posedge CLK_I) INTERNAL_BUS_MASK_WE_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        rd(4'h0, 8'h7A);
        wr(4'h0, 8'h50);
        rd(4'h1, 8'h00);
        wr(4'h0, 8'h5F);
        @(posedge CLK_I) ALL_TESTS_PASS_I <= 1'b1;
        @(posedge CLK_I) ALL_TESTS_PASS_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        #1 chk("controls", ctl, 8'h1A);
        rd(4'h1, 8'h01);
        rd(4'h0, 8'h1A);
        rd(4'hF, 8'h00);
        conclude;
    end
    initial begin
        repeat (300) @(posedge CLK_I);
        num_errors++;
        conclude;
    end
endmodule
